/* File: design/fctc_defs.vh */
// Constants for the five channel timing controller: ports, commands, fields, reset values.
// Assumes inclusion by bare name from the design file.
`ifndef FCTC_DEFS_VH
`define FCTC_DEFS_VH
`define FCTC_PORT_DATA 1'b0
`define FCTC_PORT_CTRL 1'b1
`define FCTC_OP_PTR 3'h0
`define FCTC_OP_ARM 3'h1
`define FCTC_OP_LOAD 3'h2
`define FCTC_OP_LDARM 3'h3
`define FCTC_OP_DISSAVE 3'h4
`define FCTC_OP_SAVE 3'h5
`define FCTC_OP_DISARM 3'h6
`define FCTC_OP_SINGLE 3'h7
`define FCTC_SUB_CLR 2'h0
`define FCTC_SUB_SET 2'h1
`define FCTC_SUB_STEP 2'h2
`define FCTC_CMD_CLR_SEQ 8'he0
`define FCTC_CMD_SET_SEQ 8'he8
`define FCTC_CMD_RESET 8'hff
`define FCTC_GRP_CTRL 3'h7
`define FCTC_EL_MODE 2'h0
`define FCTC_EL_LOAD 2'h1
`define FCTC_EL_HOLD 2'h2
`define FCTC_EL_ALM1 2'h0
`define FCTC_EL_ALM2 2'h1
`define FCTC_EL_MM 2'h2
`define FCTC_EL_STAT 2'h3
`define FCTC_CM_RESET 16'h0b00
`define FCTC_MM_RESET 16'h0000
`define FCTC_MM_BCD 15
`define FCTC_MM_SEQ_DIS 14
`define FCTC_MM_DIV_LSB 8
`define FCTC_MM_SRC_LSB 4
`define FCTC_CM_EDGE 12
`define FCTC_CM_SRC_LSB 8
`define FCTC_CM_RELOAD 6
`define FCTC_CM_REPEAT 5
`define FCTC_CM_BCD 4
`define FCTC_CM_UP 3
`define FCTC_OSC_HZ 4000000
`define FCTC_CLK_HZ 125000000
`define FCTC_OSC_DIV ((`FCTC_CLK_HZ + `FCTC_OSC_HZ - 1) / `FCTC_OSC_HZ)
`endif

/* File: design/fctc_timer.v */
// Five channel timing controller: command/status port, data port, prescaler, five counters.
// Assumes a host that drives one-cycle write and read strobes synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "fctc_defs.vh"

// Overview of operation
// - Control port writes are commands decoded at once, never stored.
// - Data port transfers go to the register the pointer selects.
// - Five groups each hold counter, mode, load, hold registers and an output.
// - Counter 2 drives slave request 0, counter 4 drives slave request 7.
// - Oscillator feeds 16-bit prescaler with five taps, binary or BCD.
// - Each stage divides by 16 or 10; first tap is the oscillator.
// - Divided clock counter divides a chosen tap by 1 to 16.
// - Seventh source is previous counter terminal count; counter 1 follows 5.
// - Terminal count is active the first clock after a reload.
// - Software selects count edge, binary or BCD, pulse or toggle output.
// - Code 000 loads pointer: element bits 4:3, group bits 2:0.
// - Codes 001-110: arm, load, load-arm, disarm-save, save, disarm by select mask.
// - Code 111 acts on counter N: clear output, set output, step.
// - E0 clears sequencing disable bit, E8 sets it.
// - Master reset disarms all, mode registers 0b00, master register 0000.
// - Master reset clears load and hold; counters and pointer kept.
// - Load copies load or hold register as the mode dictates.
// - Disarmed counters stop but still accept load, step and save.
// - Save copies counter into hold without disturbing counting.
// - Set and clear output follow the counter output mode.
// - Step moves counter one count in its configured direction.
// - Pointer load sets byte flag; each data transfer toggles it.
// - With sequencing on, pointer advances every second data transfer, except at the status element.
// - Groups 001-101 are counters, 111 control; 000 and 110 illegal.
// - Control group elements: alarm 1, alarm 2, master mode, status.
// - Control port read: bits 7:6 one, outputs 5..1, byte flag.
// - Pointed register is fetched to output buffer on pointer load and toggle.
module fctc_timer #(
    parameter N = 5
) (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Host port.
    input wire port_sel,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    // Counter outputs and slave interrupt requests.
    output wire [N-1:0] counter_out,
    output wire slave_irq0,
    output wire slave_irq7
);
    reg [15:0] master_configuration;
    reg [15:0] compare_value1;
    reg [15:0] compare_value2;
    reg [15:0] counter_configuration [0:N-1];
    reg [15:0] counter_reload_value [0:N-1];
    reg [15:0] counter_capture_value [0:N-1];
    reg [15:0] cnt [0:N-1];
    reg [N-1:0] armed;
    reg [N-1:0] use_hold;
    reg [N-1:0] cycle_half;
    reg [N-1:0] out_lvl;
    reg [N-1:0] terminal_count;
    reg [1:0] ptr_elem;
    reg [2:0] ptr_grp;
    reg byte_flag;
    reg [15:0] out_buf;
    reg [15:0] wr_hold;
    reg [7:0] osc_cnt;
    reg osc_tick;
    reg [3:0] psc [0:3];
    reg [3:0] div_cnt;
    reg divided_clock_output;
    reg [N-1:0] src_prev;

    wire [7:0] status = {2'b11, counter_out, byte_flag};
    wire cmd_wr = wr_stb && (port_sel == `FCTC_PORT_CTRL);
    wire data_wr = wr_stb && (port_sel == `FCTC_PORT_DATA);
    wire data_xfer = (wr_stb || rd_stb) && (port_sel == `FCTC_PORT_DATA);
    wire [2:0] op = wr_data[7:5];
    wire [2:0] cnum = wr_data[2:0];
    wire [4:0] sel = wr_data[4:0];
    wire mm_bcd = master_configuration[`FCTC_MM_BCD];
    wire [3:0] stage_max = mm_bcd ? 4'h9 : 4'hf;

    assign slave_irq0 = counter_out[1];
    assign slave_irq7 = counter_out[3];

    // Prescaler: oscillator tick, then four cascaded stages.
    wire [4:0] taps;
    assign taps[0] = osc_tick;
    genvar s;
    generate
        for (s = 0; s < 4; s = s + 1)
        begin : g_psc
            assign taps[s+1] = taps[s] && (psc[s] == stage_max);
            always @(posedge clk or posedge reset)
            begin
                if (reset)
                    psc[s] <= 4'h0;
                else if (taps[s])
                    psc[s] <= (psc[s] >= stage_max) ? 4'h0 : psc[s] + 4'h1;
            end
        end
    endgenerate

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            osc_cnt <= 8'h00;
            osc_tick <= 1'b0;
        end
        else
        begin
            osc_tick <= (osc_cnt == `FCTC_OSC_DIV - 1);
            osc_cnt <= (osc_cnt == `FCTC_OSC_DIV - 1) ? 8'h00 : osc_cnt + 8'h01;
        end
    end

    function [4:0] tap_pick;
        input [3:0] code;
        input [4:0] t;
        begin
            case (code)
                4'hc: tap_pick = {4'h0, t[1]};
                4'hd: tap_pick = {4'h0, t[2]};
                4'he: tap_pick = {4'h0, t[3]};
                4'hf: tap_pick = {4'h0, t[4]};
                default: tap_pick = {4'h0, t[0]};
            endcase
        end
    endfunction

    // Divided clock: selected tap divided by 1..16 (code 0 means 16).
    wire div_in = tap_pick(master_configuration[7:4], taps) != 5'h00;
    wire [3:0] div_max = master_configuration[11:8] - 4'h1;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            div_cnt <= 4'h0;
            divided_clock_output <= 1'b0;
        end
        else
        begin
            divided_clock_output <= div_in && (div_cnt == div_max);
            if (div_in)
                div_cnt <= (div_cnt == div_max) ? 4'h0 : div_cnt + 4'h1;
        end
    end

    function [15:0] step_val;
        input [15:0] v;
        input up;
        input bcd;
        integer i;
        reg carry;
        begin
            step_val = v;
            carry = 1'b1;
            if (!bcd)
                step_val = up ? v + 16'h0001 : v - 16'h0001;
            else
            begin
                for (i = 0; i < 4; i = i + 1)
                begin
                    if (carry)
                    begin
                        if (up)
                        begin
                            carry = (v[i*4 +: 4] == 4'h9);
                            step_val[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
                        end
                        else
                        begin
                            carry = (v[i*4 +: 4] == 4'h0);
                            step_val[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
                        end
                    end
                end
            end
        end
    endfunction

    // Register fetch for the output buffer.
    function [15:0] fetch;
        input [2:0] g;
        input [1:0] e;
        begin
            fetch = 16'h0000;
            if (g == `FCTC_GRP_CTRL)
            begin
                case (e)
                    `FCTC_EL_ALM1: fetch = compare_value1;
                    `FCTC_EL_ALM2: fetch = compare_value2;
                    `FCTC_EL_MM: fetch = master_configuration;
                    default: fetch = {8'h00, status};
                endcase
            end
            else if (g >= 3'h1 && g <= 3'h5)
            begin
                case (e)
                    `FCTC_EL_MODE: fetch = counter_configuration[g-3'h1];
                    `FCTC_EL_LOAD: fetch = counter_reload_value[g-3'h1];
                    default: fetch = counter_capture_value[g-3'h1];
                endcase
            end
        end
    endfunction

    // Pointer advance after a full word, per sequencing loop.
    wire seq_on = !master_configuration[`FCTC_MM_SEQ_DIS];
    reg [1:0] nxt_e;
    reg [2:0] nxt_g;
    always @*
    begin
        nxt_e = ptr_elem;
        nxt_g = ptr_grp;
        if (ptr_grp == `FCTC_GRP_CTRL)
        begin
            if (ptr_elem == `FCTC_EL_MM)
                nxt_e = `FCTC_EL_ALM1;
            else if (ptr_elem != `FCTC_EL_STAT)
                nxt_e = ptr_elem + 2'h1;
        end
        else if (ptr_elem == `FCTC_EL_HOLD || ptr_elem == 2'h3)
            nxt_g = (ptr_grp == 3'h5) ? 3'h1 : ptr_grp + 3'h1;
        else
            nxt_g = (ptr_grp == 3'h5) ? 3'h1 : ptr_grp + 3'h1;
    end

    wire full_word = data_xfer && !byte_flag;
    wire [1:0] adv_e = (full_word && seq_on) ? nxt_e : ptr_elem;
    wire [2:0] adv_g = (full_word && seq_on) ? nxt_g : ptr_grp;

    // Host side: pointer, byte flag, master and alarm registers, read path.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ptr_elem <= 2'h0;
            ptr_grp <= 3'h1;
            byte_flag <= 1'b1;
            out_buf <= 16'h0000;
            wr_hold <= 16'h0000;
            rd_data <= 8'h00;
            master_configuration <= `FCTC_MM_RESET;
            compare_value1 <= 16'h0000;
            compare_value2 <= 16'h0000;
        end
        else
        begin
            if (rd_stb)
                rd_data <= (port_sel == `FCTC_PORT_CTRL) ? status :
                    (byte_flag ? out_buf[7:0] : out_buf[15:8]);
            if (cmd_wr && op == `FCTC_OP_PTR)
            begin
                ptr_elem <= wr_data[4:3];
                ptr_grp <= wr_data[2:0];
                byte_flag <= 1'b1;
                out_buf <= fetch(wr_data[2:0], wr_data[4:3]);
            end
            else if (data_xfer)
            begin
                byte_flag <= !byte_flag;
                ptr_elem <= adv_e;
                ptr_grp <= adv_g;
                out_buf <= fetch(adv_g, adv_e);
                if (data_wr && byte_flag)
                    wr_hold[7:0] <= wr_data;
            end
            if (cmd_wr && wr_data == `FCTC_CMD_RESET)
                master_configuration <= `FCTC_MM_RESET;
            else if (cmd_wr && wr_data == `FCTC_CMD_CLR_SEQ)
                master_configuration[`FCTC_MM_SEQ_DIS] <= 1'b0;
            else if (cmd_wr && wr_data == `FCTC_CMD_SET_SEQ)
                master_configuration[`FCTC_MM_SEQ_DIS] <= 1'b1;
            else if (data_wr && !byte_flag && ptr_grp == `FCTC_GRP_CTRL)
            begin
                case (ptr_elem)
                    `FCTC_EL_ALM1: compare_value1 <= {wr_data, wr_hold[7:0]};
                    `FCTC_EL_ALM2: compare_value2 <= {wr_data, wr_hold[7:0]};
                    `FCTC_EL_MM: master_configuration <= {wr_data, wr_hold[7:0]};
                    default: ;
                endcase
            end
        end
    end

    // Counter groups.
    genvar c;
    generate
        for (c = 0; c < N; c = c + 1)
        begin : g_cnt
            wire [15:0] cm = counter_configuration[c];
            wire [15:0] reload = use_hold[c] ? counter_capture_value[c] : counter_reload_value[c];
            wire prev_tc = terminal_count[(c + N - 1) % N];
            wire [3:0] sc = cm[11:8];
            wire src = (sc == 4'h0) ? prev_tc :
                (sc == 4'h1) ? divided_clock_output :
                (tap_pick(sc, taps) != 5'h00);
            wire tick = cm[`FCTC_CM_EDGE] ? (src_prev[c] && !src) : (!src_prev[c] && src);
            wire [15:0] top_val = cm[`FCTC_CM_BCD] ? 16'h9999 : 16'hffff;
            wire at_end = cm[`FCTC_CM_UP] ? (cnt[c] == top_val) : (cnt[c] == 16'h0001);
            wire sel_bit = cmd_wr && sel[c];
            wire single = cmd_wr && op == `FCTC_OP_SINGLE && cnum == c + 1;
            wire my_word = data_wr && !byte_flag && ptr_grp == c + 1;
            wire [2:0] om = cm[2:0];
            always @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    cnt[c] <= 16'h0000;
                    armed[c] <= 1'b0;
                    use_hold[c] <= 1'b0;
                    cycle_half[c] <= 1'b0;
                    out_lvl[c] <= 1'b0;
                    terminal_count[c] <= 1'b0;
                    src_prev[c] <= 1'b0;
                    counter_configuration[c] <= `FCTC_CM_RESET;
                    counter_reload_value[c] <= 16'h0000;
                    counter_capture_value[c] <= 16'h0000;
                end
                else
                begin
                    src_prev[c] <= src;
                    terminal_count[c] <= 1'b0;
                    // Counting runs first so that commands in the same cycle take precedence over a tick.
                    if (armed[c] && tick)
                    begin
                        if (at_end)
                        begin
                            cnt[c] <= reload;
                            terminal_count[c] <= 1'b1;
                            if (cm[`FCTC_CM_RELOAD])
                                use_hold[c] <= !use_hold[c];
                            cycle_half[c] <= cm[`FCTC_CM_RELOAD] && !cycle_half[c];
                            if (!cm[`FCTC_CM_REPEAT] && (!cm[`FCTC_CM_RELOAD] || cycle_half[c]))
                                armed[c] <= 1'b0;
                            if (om == 3'h2)
                                out_lvl[c] <= !out_lvl[c];
                        end
                        else
                            cnt[c] <= step_val(cnt[c], cm[`FCTC_CM_UP], cm[`FCTC_CM_BCD]);
                    end
                    if (cmd_wr && wr_data == `FCTC_CMD_RESET)
                    begin
                        armed[c] <= 1'b0;
                        counter_configuration[c] <= `FCTC_CM_RESET;
                        counter_reload_value[c] <= 16'h0000;
                        counter_capture_value[c] <= 16'h0000;
                        use_hold[c] <= 1'b0;
                    end
                    else if (sel_bit && op != `FCTC_OP_PTR && op != `FCTC_OP_SINGLE)
                    begin
                        if (op == `FCTC_OP_ARM || op == `FCTC_OP_LDARM)
                            armed[c] <= 1'b1;
                        if (op == `FCTC_OP_DISSAVE || op == `FCTC_OP_DISARM)
                            armed[c] <= 1'b0;
                        if (op == `FCTC_OP_LOAD || op == `FCTC_OP_LDARM)
                            cnt[c] <= reload;
                        if (op == `FCTC_OP_DISSAVE || op == `FCTC_OP_SAVE)
                            counter_capture_value[c] <= cnt[c];
                    end
                    else if (single && wr_data[4:3] == `FCTC_SUB_STEP)
                        cnt[c] <= step_val(cnt[c], cm[`FCTC_CM_UP], cm[`FCTC_CM_BCD]);
                    else if (single && wr_data[4:3] == `FCTC_SUB_SET)
                        out_lvl[c] <= (om == 3'h0) ? 1'b0 : (om != 3'h5);
                    else if (single && wr_data[4:3] == `FCTC_SUB_CLR)
                        out_lvl[c] <= (om == 3'h5);
                    else if (my_word)
                    begin
                        case (ptr_elem)
                            `FCTC_EL_MODE: counter_configuration[c] <= {wr_data, wr_hold[7:0]};
                            `FCTC_EL_LOAD: counter_reload_value[c] <= {wr_data, wr_hold[7:0]};
                            default: counter_capture_value[c] <= {wr_data, wr_hold[7:0]};
                        endcase
                    end
                end
            end
            assign counter_out[c] = (om == 3'h0) ? 1'b0 : (om == 3'h1) ? terminal_count[c] :
                (om == 3'h5) ? !terminal_count[c] && out_lvl[c] : out_lvl[c];
        end
    endgenerate
endmodule // fctc_timer
`default_nettype wire

/* File: bench/fctc_host.sv */
// Host model: drives the control and data ports with one-cycle strobes.
// Assumes a free-running clk and callers that wait for reset release.
`timescale 1ns/1ps
`default_nettype none
module fctc_host (
    // Clock.
    input wire logic clk,
    // Host port.
    output logic port_sel,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    initial
    begin
        port_sel = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        wr_data = 8'h00;
    end
    // Writes one byte; callers keep pointer loads and transfers together.
    task automatic put(input logic s, input logic [7:0] d);
        @(posedge clk);
        port_sel <= s;
        wr_stb <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        wr_data <= ~d;
    endtask
    // Reads one byte; the answer is registered at the sampling edge.
    task automatic get(input logic s, output logic [7:0] d);
        @(posedge clk);
        port_sel <= s;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask
endmodule // fctc_host
`default_nettype wire

/* File: bench/fctc_timer_asserts.sv */
// Checker for the timing controller ports: status, flag and output mapping.
// Assumes the host spaces accesses one idle cycle apart.
`timescale 1ns/1ps
`default_nettype none
module fctc_timer_checker #(
    parameter N = 5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Host port.
    input wire logic port_sel,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    // Outputs.
    input wire logic [N-1:0] counter_out,
    input wire logic slave_irq0,
    input wire logic slave_irq7
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    wire ctrl_rd = rd_stb && port_sel;
    wire idle = !rd_stb && !wr_stb;
    wire ptr_wr = wr_stb && port_sel && wr_data[7:5] == 3'h0;
    wire data_x = (rd_stb || wr_stb) && !port_sel;
    wire mr_wr = wr_stb && port_sel && wr_data == 8'hff;
    property p_irq0; slave_irq0 == counter_out[1]; endproperty
    a_irq0: assert property (p_irq0)
        else $error("slave_irq0 differs from output two");
    property p_irq7; slave_irq7 == counter_out[3]; endproperty
    a_irq7: assert property (p_irq7)
        else $error("slave_irq7 differs from output four");
    property p_rd_hold; !rd_stb |=> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    property p_ones; ctrl_rd |=> rd_data[7:6] == 2'b11; endproperty
    a_ones: assert property (p_ones)
        else $error("status top bits not one");
    property p_outs; ctrl_rd |=> rd_data[5:1] == $past(counter_out); endproperty
    a_outs: assert property (p_outs)
        else $error("status output bits wrong");
    property p_ptr_flag; ptr_wr ##1 idle ##1 ctrl_rd |=> rd_data[0]; endproperty
    a_ptr_flag: assert property (p_ptr_flag)
        else $error("byte flag not set after pointer load");
    sequence s_one_xfer;
        ptr_wr ##1 idle ##1 data_x ##1 idle ##1 ctrl_rd;
    endsequence
    property p_xfer_flag; s_one_xfer |=> !rd_data[0]; endproperty
    a_xfer_flag: assert property (p_xfer_flag)
        else $error("byte flag not toggled by transfer");
    property p_mreset; mr_wr ##1 idle ##1 ctrl_rd |=> rd_data[7:1] == 7'h60; endproperty
    a_mreset: assert property (p_mreset)
        else $error("outputs not off after master reset");
endmodule // fctc_timer_checker
bind fctc_timer fctc_timer_checker #(.N(N)) fctc_timer_checker_i (.clk(clk), .reset(reset),
    .port_sel(port_sel), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
    .rd_data(rd_data), .counter_out(counter_out), .slave_irq0(slave_irq0),
    .slave_irq7(slave_irq7));
`default_nettype wire

/* File: bench/five_channel_timing_controller_tb.sv */
// Testbench for the timing controller: registers, commands, sequencing, outputs.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module five_channel_timing_controller_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic port_sel;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [4:0] counter_out;
    logic slave_irq0;
    logic slave_irq7;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] w;
    logic [7:0] b;
    always #4 clk = ~clk;
    fctc_timer #(.N(5)) fctc_timer_i (.clk(clk), .reset(reset), .port_sel(port_sel),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data),
        .counter_out(counter_out), .slave_irq0(slave_irq0), .slave_irq7(slave_irq7));
    fctc_host fctc_host_i (.clk(clk), .port_sel(port_sel), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        fctc_host_i.put(1'b1, c);
    endtask
    task automatic dput(input logic [15:0] v);
        fctc_host_i.put(1'b0, v[7:0]);
        fctc_host_i.put(1'b0, v[15:8]);
    endtask
    task automatic wrw(input logic [7:0] p, input logic [15:0] v);
        cmd(p);
        dput(v);
    endtask
    task automatic chw(input logic [7:0] p, input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        cmd(p);
        fctc_host_i.get(1'b0, lo);
        fctc_host_i.get(1'b0, hi);
        chk({hi, lo}, e);
    endtask
    task automatic chs(input logic [7:0] e);
        fctc_host_i.get(1'b1, b);
        chk({8'h00, b}, {8'h00, e});
    endtask
    task automatic out_is(input logic [4:0] e);
        #1;
        chk({9'h000, slave_irq7, slave_irq0, counter_out}, {9'h000, e[3], e[1], e});
    endtask
    task automatic t_reset;
        chs(8'hc1);
        chw(8'h17, 16'h0000);
        chw(8'h01, 16'h0b00);
        cmd(8'he8);
        chw(8'h17, 16'h4000);
        cmd(8'he0);
        chw(8'h17, 16'h0000);
        cmd(8'he8);
    endtask
    task automatic t_regs;
        cmd(8'h09);
        chs(8'hc1);
        cmd(8'h09);
        fctc_host_i.get(1'b0, b);
        chs(8'hc0);
        fctc_host_i.get(1'b0, b);
        for (int g = 0; g < 8; g++)
            wrw(8'h08 + 8'(g), 16'h1100 + 16'(g));
        for (int g = 1; g < 8; g++)
            if (g != 6)
                chw(8'h08 + 8'(g), 16'h1100 + 16'(g));
        wrw(8'h07, 16'ha55a);
        chw(8'h07, 16'ha55a);
    endtask
    task automatic t_seq;
        cmd(8'he0);
        cmd(8'h09);
        for (int g = 1; g < 7; g++)
            dput(16'h2000 + 16'(g));
        cmd(8'he8);
        for (int g = 1; g < 6; g++)
            chw(8'h08 + 8'(g), (g == 1) ? 16'h2006 : 16'h2000 + 16'(g));
    endtask
    task automatic t_mreset;
        wrw(8'h11, 16'h7777);
        wrw(8'h01, 16'h0b28);
        cmd(8'h07);
        cmd(8'hff);
        chs(8'hc1);
        fctc_host_i.get(1'b0, b);
        chk({8'h00, b}, 16'h005a);
        chw(8'h01, 16'h0b00);
        chw(8'h09, 16'h0000);
        chw(8'h11, 16'h0000);
        chw(8'h17, 16'h0000);
    endtask
    task automatic t_count;
        cmd(8'he8);
        wrw(8'h09, 16'h0005);
        cmd(8'h41);
        cmd(8'ha1);
        chw(8'h11, 16'h0005);
        cmd(8'hf1);
        cmd(8'h81);
        chw(8'h11, 16'h0004);
        wrw(8'h01, 16'h0b08);
        cmd(8'hf1);
        cmd(8'ha1);
        chw(8'h11, 16'h0005);
    endtask
    task automatic t_out;
        wrw(8'h02, 16'h0b02);
        wrw(8'h04, 16'h0b02);
        cmd(8'hea);
        out_is(5'h02);
        cmd(8'hec);
        out_is(5'h0a);
        chs(8'hd5);
        cmd(8'hee);
        cmd(8'hef);
        cmd(8'he9);
        out_is(5'h0a);
        cmd(8'he2);
        cmd(8'he4);
        out_is(5'h00);
    endtask
    task automatic t_run;
        wrw(8'h09, 16'h0003);
        wrw(8'h01, 16'h0b22);
        cmd(8'h61);
        repeat (120) @(posedge clk);
        out_is(5'h01);
        repeat (80) @(posedge clk);
        out_is(5'h00);
        cmd(8'hc1);
        repeat (96) @(posedge clk);
        out_is(5'h00);
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_seq();
        t_mreset();
        t_count();
        t_out();
        t_run();
        summarize();
    end
endmodule // five_channel_timing_controller_tb
`default_nettype wire
